// >>> hdl/pbsp_port.sv
// top of the pipelined double-cycle-deselect burst sram port
`timescale 1ns/1ps
`default_nettype none

module pbsp_port (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic [pbsp_pkg::ADDR_W-1:0]   addr,
  input  wire logic                          processor_addr_strobe_n,
  input  wire logic                          controller_addr_strobe_n,
  input  wire logic                          burst_advance_n,
  input  wire logic                          global_write_n,
  input  wire logic                          byte_write_enable_n,
  input  wire logic [pbsp_pkg::LANES-1:0]    byte_lane_select_n,
  input  wire logic                          chip_select_first_n,
  input  wire logic                          chip_select_second,
  input  wire logic                          chip_select_third_n,
  input  wire logic                          burst_order_sel,
  input  wire logic                          output_enable_n,
  input  wire logic [pbsp_pkg::DATA_W-1:0]   dq_in,
  output logic      [pbsp_pkg::DATA_W-1:0]   dq_out,
  output logic                               dq_oe
);

  // ************************************************************
  // declarations
  // ************************************************************
  pbsp_pkg::pbsp_state_t                state_reg;
  pbsp_pkg::pbsp_state_t                state_next;
  pbsp_pkg::pbsp_mem_cmd_t              mem_cmd;
  pbsp_pkg::pbsp_wctl_t                 wctl;
  logic [pbsp_pkg::ADDR_W-1:0]          addr_reg;
  logic [pbsp_pkg::BURST_W-1:0]         start_reg;
  logic [pbsp_pkg::BURST_W-1:0]         step_reg;
  logic [pbsp_pkg::BURST_W-1:0]         step_next;
  logic                                 mode_reg;
  logic                                 read_pend_reg;
  logic [pbsp_pkg::DATA_W-1:0]          dq_out_reg;
  logic                                 dq_oe_reg;
  logic [pbsp_pkg::DATA_W-1:0]          mem_rdata;
  logic [pbsp_pkg::LANES-1:0]           lane_we;
  logic                                 selected;
  logic                                 write_req;
  logic                                 proc_hit;
  logic                                 ctrl_hit;
  logic                                 start_proc;
  logic                                 start_ctrl;
  logic                                 deselect;
  logic                                 cont;
  logic                                 wr_op;
  logic                                 rd_op;

  // ************************************************************
  // access decode
  // ************************************************************
  // every control pin is taken at the edge it is decoded on; the
  // address, counter and state flops below are the input registers
  assign wctl       = {global_write_n, byte_write_enable_n, byte_lane_select_n};
  assign lane_we    = pbsp_pkg::pbsp_lane_we(wctl);
  assign write_req  = lane_we != pbsp_pkg::LANES_NONE;

  assign selected = !chip_select_first_n && chip_select_second
                    && !chip_select_third_n;
  assign proc_hit = !processor_addr_strobe_n
                    && !chip_select_first_n;
  assign ctrl_hit = !proc_hit
                    && !controller_addr_strobe_n;

  assign start_proc = proc_hit && selected;
  assign start_ctrl = ctrl_hit && selected;
  assign deselect   = (proc_hit || ctrl_hit) && !selected;
  assign cont       = !proc_hit && controller_addr_strobe_n
                      && state_reg == pbsp_pkg::PBSP_ST_ACTIVE;

  // a processor start is always a read whatever the write pins say
  assign wr_op = (start_ctrl || cont) && write_req;
  assign rd_op = start_proc
                 || ((start_ctrl || cont) && !write_req);

  // ************************************************************
  // burst counter
  // ************************************************************
  always_comb begin
    step_next = step_reg;
    if (cont && !burst_advance_n) begin
      step_next = step_reg + pbsp_pkg::BURST_K_ONE;
    end
  end

  // a start ignores the advance pin; the step restarts at zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      step_reg <= pbsp_pkg::BURST_K_RST;
    end else if (start_proc || start_ctrl) begin
      step_reg <= pbsp_pkg::BURST_K_RST;
    end else begin
      step_reg <= step_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_reg  <= pbsp_pkg::ADDR_RST;
      start_reg <= pbsp_pkg::BURST_K_RST;
    end else if (start_proc || start_ctrl) begin
      addr_reg  <= addr;
      start_reg <= addr[pbsp_pkg::BURST_W-1:0];
    end
  end

  // the strap is caught while reset is held and kept afterwards, so a
  // wobble on the pin during operation cannot corrupt a burst
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_reg <= burst_order_sel;
    end
  end

  // ************************************************************
  // selection state
  // ************************************************************
  always_comb begin
    case (state_reg)
      pbsp_pkg::PBSP_ST_DESEL: begin
        state_next = (start_proc || start_ctrl)
                     ? pbsp_pkg::PBSP_ST_ACTIVE : pbsp_pkg::PBSP_ST_DESEL;
      end
      pbsp_pkg::PBSP_ST_ACTIVE: begin
        state_next = deselect
                     ? pbsp_pkg::PBSP_ST_DESEL : pbsp_pkg::PBSP_ST_ACTIVE;
      end
      default: begin
        state_next = pbsp_pkg::PBSP_ST_DESEL;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= pbsp_pkg::PBSP_ST_DESEL;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // array access
  // ************************************************************
  always_comb begin
    mem_cmd.en    = rd_op || wr_op;
    mem_cmd.we    = wr_op ? lane_we : pbsp_pkg::LANES_NONE;
    mem_cmd.wdata = dq_in;
    if (start_proc || start_ctrl) begin
      mem_cmd.addr = addr;
    end else begin
      mem_cmd.addr = {addr_reg[pbsp_pkg::ADDR_W-1:pbsp_pkg::BURST_W],
                      pbsp_pkg::pbsp_burst_low(start_reg, step_next, mode_reg)};
    end
  end

  pbsp_mem u_mem (
    .sys_clk (sys_clk),
    .cmd     (mem_cmd),
    .rdata   (mem_rdata)
  );

  // ************************************************************
  // output pipeline
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      read_pend_reg <= 1'h0;
    end else begin
      read_pend_reg <= rd_op;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dq_out_reg <= pbsp_pkg::DQ_RST;
    end else if (read_pend_reg) begin
      dq_out_reg <= mem_rdata;
    end
  end

  // the enable follows the data one stage behind the access, which gives
  // the masked first cycle after a deselect and the one extra driven
  // cycle after a deselect for free; output enable is sampled, not
  // asynchronous, so it acts one edge late
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dq_oe_reg <= 1'h0;
    end else begin
      dq_oe_reg <= read_pend_reg && !output_enable_n
                   && !wr_op;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe  = dq_oe_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // a processor strobe with the first select high must look like a plain
  // continue: no address load and no change of selection
  first_sel_gate_a: assert property (
    (chip_select_first_n && !processor_addr_strobe_n && controller_addr_strobe_n)
    |=> addr_reg == $past(addr_reg) && state_reg == $past(state_reg))
    else $error("processor strobe acted with first select high");

  read_start_a: assert property (
    (!processor_addr_strobe_n && selected) |-> rd_op && mem_cmd.we == pbsp_pkg::LANES_NONE)
    else $error("selected strobe did not start a read");

  read_drive_a: assert property (
    (rd_op && state_reg == pbsp_pkg::PBSP_ST_ACTIVE) ##1 (!output_enable_n && !wr_op)
    |=> dq_oe && dq_out == $past(mem_rdata))
    else $error("read data not driven after the next edge");

  first_mask_a: assert property (
    (state_reg == pbsp_pkg::PBSP_ST_DESEL && rd_op) |=> !dq_oe)
    else $error("output driven in first cycle after deselect");

  desel_hold_a: assert property (
    (deselect && read_pend_reg && !output_enable_n && !wr_op) |=> dq_oe ##1 !dq_oe)
    else $error("deselect did not give exactly one more driven cycle");

  write_off_a: assert property (
    wr_op |=> !dq_oe)
    else $error("outputs driven during a write");

  global_all_a: assert property (
    (wr_op && !global_write_n) |-> mem_cmd.we == pbsp_pkg::LANES_ALL)
    else $error("global write did not write all lanes");

  lane_only_a: assert property (
    (wr_op && global_write_n) |-> mem_cmd.we == ~byte_lane_select_n)
    else $error("byte write touched unselected lanes");

  ctrl_write_a: assert property (
    (!controller_addr_strobe_n && processor_addr_strobe_n && selected && write_req)
    |-> wr_op && mem_cmd.addr == addr)
    else $error("controller strobe write not started");

  proc_write_a: assert property (
    start_proc ##1 (controller_addr_strobe_n && burst_advance_n
                    && (processor_addr_strobe_n || chip_select_first_n) && write_req)
    |-> mem_cmd.we != pbsp_pkg::LANES_NONE && mem_cmd.addr == addr_reg)
    else $error("processor write not done at second edge");

  step_adv_a: assert property (
    (cont && !burst_advance_n) |=> step_reg == $past(step_reg) + pbsp_pkg::BURST_K_ONE)
    else $error("advance did not step the counter");

  both_strobe_a: assert property (
    (!processor_addr_strobe_n && !controller_addr_strobe_n && !chip_select_first_n)
    |-> !ctrl_hit && !wr_op)
    else $error("controller strobe acted beside processor strobe");

  // ************************************************************
  // checks on the burst counter
  // ************************************************************
  // expected low bits come from the previous array access, not from the
  // counter, so a wrong step count and a wrong order both show up
  logic [pbsp_pkg::BURST_W-1:0]         last_low_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_low_reg <= pbsp_pkg::BURST_K_RST;
    end else begin
      last_low_reg <= mem_cmd.addr[pbsp_pkg::BURST_W-1:0];
    end
  end

  start_load_a: assert property (
    (start_proc || start_ctrl)
    |=> start_reg == last_low_reg && addr_reg == $past(addr))
    else $error("start did not load the address registers");

  start_step_a: assert property (
    (start_proc || start_ctrl) |=> step_reg == pbsp_pkg::BURST_K_RST)
    else $error("start did not clear the burst step");

  lin_next_a: assert property (
    (mem_cmd.en ##1 (cont && !burst_advance_n && mode_reg == pbsp_pkg::MODE_LINEAR))
    |-> mem_cmd.addr[pbsp_pkg::BURST_W-1:0] == last_low_reg + pbsp_pkg::BURST_K_ONE)
    else $error("linear burst did not add one");

  ilv_next_a: assert property (
    ((start_proc || start_ctrl) ##1 (cont && !burst_advance_n && mode_reg != pbsp_pkg::MODE_LINEAR))
    |-> mem_cmd.addr == ($past(addr) ^ 16'h1))
    else $error("interleaved burst second address wrong");

  ilv_third_a: assert property (
    ((start_proc || start_ctrl) ##1 (cont && !burst_advance_n && mode_reg != pbsp_pkg::MODE_LINEAR)
     ##1 (cont && !burst_advance_n))
    |-> mem_cmd.addr == ($past(addr, 2) ^ 16'h2))
    else $error("interleaved burst third address wrong");

  // the counter is two bits wide: a burst never leaves its group of four
  burst_wrap_a: assert property (
    (mem_cmd.en ##1 cont)
    |-> (mem_cmd.addr >> pbsp_pkg::BURST_W) == ($past(mem_cmd.addr) >> pbsp_pkg::BURST_W))
    else $error("burst left its group of four");

  // ************************************************************
  // checks on selection and output enable
  // ************************************************************
  desel_quiet_a: assert property (
    (state_reg == pbsp_pkg::PBSP_ST_DESEL && !start_proc && !start_ctrl) |-> !mem_cmd.en)
    else $error("array touched while deselected");

  sel_leave_a: assert property (
    deselect |=> state_reg == pbsp_pkg::PBSP_ST_DESEL && !read_pend_reg)
    else $error("deselect not registered");

  oe_gate_a: assert property (
    output_enable_n |=> !dq_oe)
    else $error("outputs driven with output enable high");

  read_data_a: assert property (
    read_pend_reg |=> dq_out == $past(mem_rdata))
    else $error("read data did not pass the output register");

endmodule : pbsp_port

`default_nettype wire

// >>> hdl/pbsp_pkg.sv
// constants, types and helpers shared by the pipelined burst sram port
`default_nettype none

package pbsp_pkg;

  // ************************************************************
  // sizes and values after reset
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int LANES  = 2;
  localparam int LANE_W = 9;
  localparam int DEPTH  = 65536;
  localparam int BURST_W = 2;

  localparam logic                MODE_LINEAR = 1'h0;
  localparam logic [BURST_W-1:0]  BURST_K_RST = 2'h0;
  localparam logic [BURST_W-1:0]  BURST_K_ONE = 2'h1;
  localparam logic [DATA_W-1:0]   DQ_RST      = 18'h0;
  localparam logic [ADDR_W-1:0]   ADDR_RST    = 16'h0;
  localparam logic [LANES-1:0]    LANES_ALL   = 2'h3;
  localparam logic [LANES-1:0]    LANES_NONE  = 2'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [0:0] {
    PBSP_ST_DESEL  = 1'b0,
    PBSP_ST_ACTIVE = 1'b1
  } pbsp_state_t;

  typedef struct packed {
    logic               en;
    logic [LANES-1:0]   we;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } pbsp_mem_cmd_t;

  typedef struct packed {
    logic               glob_n;
    logic               byte_en_n;
    logic [LANES-1:0]   bls_n;
  } pbsp_wctl_t;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [BURST_W-1:0] pbsp_burst_low(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] step,
    input logic               mode
  );
    if (mode == MODE_LINEAR) begin
      pbsp_burst_low = start + step;
    end else begin
      pbsp_burst_low = start ^ step;
    end
  endfunction : pbsp_burst_low

  // global write beats lane selects; nothing is written otherwise
  function automatic logic [LANES-1:0] pbsp_lane_we(input pbsp_wctl_t w);
    if (!w.glob_n) begin
      pbsp_lane_we = LANES_ALL;
    end else if (!w.byte_en_n) begin
      pbsp_lane_we = ~w.bls_n;
    end else begin
      pbsp_lane_we = LANES_NONE;
    end
  endfunction : pbsp_lane_we

endpackage : pbsp_pkg

`default_nettype wire

// >>> hdl/pbsp_mem.sv
// storage array of the burst sram port with lane writes and registered read data
`timescale 1ns/1ps
`default_nettype none

module pbsp_mem (
  input  wire logic                          sys_clk,
  input  wire pbsp_pkg::pbsp_mem_cmd_t       cmd,
  output logic [pbsp_pkg::DATA_W-1:0]        rdata
);

  logic [pbsp_pkg::DATA_W-1:0] mem_array [0:pbsp_pkg::DEPTH-1];

  // ************************************************************
  // write port
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (cmd.en) begin
      for (int i = 0; i < pbsp_pkg::LANES; i++) begin
        if (cmd.we[i]) begin
          mem_array[cmd.addr][i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] <=
            cmd.wdata[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
        end
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // read data holds between reads, so a suspended burst sees stable data
  always_ff @(posedge sys_clk) begin
    if (cmd.en && cmd.we == pbsp_pkg::LANES_NONE) begin
      rdata <= mem_array[cmd.addr];
    end
  end

endmodule : pbsp_mem

`default_nettype wire

// >>> tb/pbsp_host_model.sv
// controller-side pin model driving the burst sram port
`timescale 1ns/1ps
`default_nettype none

module pbsp_host_model (
  input  wire logic                        sys_clk,
  output logic [pbsp_pkg::ADDR_W-1:0]      addr,
  output logic                             processor_addr_strobe_n,
  output logic                             controller_addr_strobe_n,
  output logic                             burst_advance_n,
  output logic                             global_write_n,
  output logic                             byte_write_enable_n,
  output logic [pbsp_pkg::LANES-1:0]       byte_lane_select_n,
  output logic                             chip_select_first_n,
  output logic                             chip_select_second,
  output logic                             chip_select_third_n,
  output logic                             burst_order_sel,
  output logic                             output_enable_n,
  output logic [pbsp_pkg::DATA_W-1:0]      dq_in
);
  // when set, write data goes out with output enable still low
  logic rude = 1'h0;

  // ************************************************************
  // pin driving
  // ************************************************************
  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {global_write_n, byte_write_enable_n, byte_lane_select_n} = 4'hf;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h6;
    burst_order_sel = 1'h1;
    output_enable_n = 1'h1;
    addr = 16'h0;
    dq_in = 18'h0;
  end

  // strap moves only while the tb holds reset
  task automatic set_mode(input logic m);
    burst_order_sel = m;
  endtask : set_mode

  // c = {processor strobe, controller strobe, advance, global write, byte enable}; sel 0 selects
  task automatic step(input logic [4:0] c, input logic [1:0] bls, input logic [1:0] sel,
                      input logic [15:0] a, input logic [17:0] d, input logic oe);
    logic wr;
    @(negedge sys_clk);
    wr = !c[1] || (!c[0] && bls != 2'h3);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n,
     byte_write_enable_n} = c;
    byte_lane_select_n = bls;
    chip_select_first_n = (sel == 2'h1);
    chip_select_second = (sel != 2'h2);
    chip_select_third_n = (sel == 2'h3);
    addr = a;
    output_enable_n = wr ? !rude : oe;
    // released data lines must not keep the old value
    dq_in = wr ? d : ~dq_in;
    @(posedge sys_clk);
    #1;
  endtask : step
endmodule : pbsp_host_model

`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the pipelined burst sram port
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                 sys_clk = 1'h0;
  logic                 srst = 1'h1;
  logic [15:0]          addr;
  logic                 ps_n, cs_n, ba_n, wg_n, be_n, s1_n, s2, s3_n, mode, oe_n, dq_oe;
  logic [1:0]           bls_n;
  logic [17:0]          dq_in, dq_out, d, e;
  logic [17:0]          shadow [logic [15:0]];
  logic [15:0]          av [8];
  logic [15:0]          base;
  logic [1:0]           ln;
  logic [31:0]          lfsr_reg = 32'h500cde51;
  int                   fail_count = 0;
  int                   compares = 0;
  int                   i, k, m;

  always #2.5 sys_clk = ~sys_clk;

  pbsp_host_model host (.sys_clk(sys_clk), .addr(addr), .processor_addr_strobe_n(ps_n),
    .controller_addr_strobe_n(cs_n), .burst_advance_n(ba_n), .global_write_n(wg_n),
    .byte_write_enable_n(be_n), .byte_lane_select_n(bls_n), .chip_select_first_n(s1_n),
    .chip_select_second(s2), .chip_select_third_n(s3_n), .burst_order_sel(mode),
    .output_enable_n(oe_n), .dq_in(dq_in));

  pbsp_port DUT (.sys_clk(sys_clk), .srst(srst), .addr(addr), .processor_addr_strobe_n(ps_n),
    .controller_addr_strobe_n(cs_n), .burst_advance_n(ba_n), .global_write_n(wg_n),
    .byte_write_enable_n(be_n), .byte_lane_select_n(bls_n), .chip_select_first_n(s1_n),
    .chip_select_second(s2), .chip_select_third_n(s3_n), .burst_order_sel(mode),
    .output_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg;
  endfunction : rnd

  function automatic logic [1:0] seq_low(input logic [1:0] s, input logic [1:0] n, input logic md);
    return md ? (s ^ n) : (s + n);
  endfunction : seq_low

  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset(input logic md);
    @(negedge sys_clk);
    srst = 1'h1;
    host.set_mode(md);
    repeat (20) @(negedge sys_clk);
    chk("oe in reset", {17'h0, dq_oe}, 18'h0);
    chk("data in reset", dq_out, 18'h0);
    srst = 1'h0;
  endtask : do_reset

  task automatic wr(input logic [15:0] a, input logic [17:0] dv);
    host.step(5'h15, 2'h3, 2'h0, a, dv, 1'h1);
    shadow[a] = dv;
  endtask : wr

  // start on the processor strobe, data is in the output register one edge later
  task automatic rd(input logic [15:0] a);
    host.step(5'h0f, 2'h3, 2'h0, a, 18'h0, 1'h0);
    host.step(5'h1f, 2'h3, 2'h0, a, 18'h0, 1'h0);
    chk("read data", dq_out, shadow[a]);
  endtask : rd

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    do_reset(1'h1);
    for (i = 0; i < 8; i++) begin
      av[i] = rnd();
      wr(av[i], rnd());
    end
    for (i = 0; i < 8; i++) rd(av[i]);
    // back-to-back starts keep the pipeline full
    host.step(5'h0f, 2'h3, 2'h0, av[0], 18'h0, 1'h0);
    host.step(5'h0f, 2'h3, 2'h0, av[1], 18'h0, 1'h0);
    chk("pipelined first", dq_out, shadow[av[0]]);
    host.step(5'h1f, 2'h3, 2'h0, av[1], 18'h0, 1'h0);
    chk("pipelined second", dq_out, shadow[av[1]]);
    chk("oe pipelined", {17'h0, dq_oe}, 18'h1);
    // every lane select pattern on the controller strobe; all high means a read
    for (i = 0; i < 4; i++) begin
      ln = i[1:0];
      d = rnd();
      host.step(5'h16, ln, 2'h0, av[0], d, 1'h1);
      e = shadow[av[0]];
      if (!ln[0]) e[8:0] = d[8:0];
      if (!ln[1]) e[17:9] = d[17:9];
      shadow[av[0]] = e;
      rd(av[0]);
    end
    d = rnd();
    host.step(5'h14, 2'h3, 2'h0, av[1], d, 1'h1);
    shadow[av[1]] = d;
    rd(av[1]);
    // both strobes with global write: the start stays a read, lane 0 written next edge
    d = rnd();
    host.step(5'h04, 2'h0, 2'h0, av[2], ~d, 1'h1);
    host.step(5'h1e, 2'h2, 2'h0, av[2], d, 1'h1);
    shadow[av[2]][8:0] = d[8:0];
    rd(av[2]);
    // processor strobe with first select high is ignored: continue writes old address
    host.step(5'h17, 2'h3, 2'h0, av[3], 18'h0, 1'h1);
    d = rnd();
    host.step(5'h0d, 2'h3, 2'h1, av[4], d, 1'h1);
    shadow[av[3]] = d;
    rd(av[3]);
    rd(av[4]);
    // each way of deselecting, then a fresh read out of the deselected state
    for (i = 1; i < 4; i++) begin
      rd(av[5]);
      host.step(5'h1f, 2'h3, 2'h0, av[5], 18'h0, 1'h0);
      chk("oe reading", {17'h0, dq_oe}, 18'h1);
      host.step(5'h17, 2'h3, i[1:0], av[6], 18'h0, 1'h0);
      chk("oe deselect edge", {17'h0, dq_oe}, 18'h1);
      host.step(5'h1d, 2'h3, 2'h0, av[6], rnd(), 1'h0);
      chk("oe after deselect", {17'h0, dq_oe}, 18'h0);
      // the first cycle of the access is the one right after the start edge
      host.step(5'h0f, 2'h3, 2'h0, av[6], 18'h0, 1'h0);
      chk("oe first cycle", {17'h0, dq_oe}, 18'h0);
      host.step(5'h1f, 2'h3, 2'h0, av[6], 18'h0, 1'h0);
      chk("no write deselected", dq_out, shadow[av[6]]);
      chk("oe second cycle", {17'h0, dq_oe}, 18'h1);
    end
    // write while output enable is still low
    rd(av[7]);
    host.rude = 1'h1;
    wr(av[7], rnd());
    chk("oe in write", {17'h0, dq_oe}, 18'h0);
    host.rude = 1'h0;
    rd(av[7]);
    // bursts from every start in both orders
    for (m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (i = 0; i < 4; i++) begin
        base = rnd();
        base[1:0] = i[1:0];
        d = rnd();
        wr(base, d);
        for (k = 1; k < 4; k++) begin
          d = d + 18'h1;
          host.step(5'h19, 2'h3, 2'h0, base, d, 1'h1);
          shadow[{base[15:2], seq_low(i[1:0], k[1:0], m[0])}] = d;
        end
        for (k = 0; k < 4; k++) rd({base[15:2], k[1:0]});
        host.step(5'h0f, 2'h3, 2'h0, base, 18'h0, 1'h0);
        for (k = 1; k < 5; k++) begin
          host.step((k < 4) ? 5'h1b : 5'h1f, 2'h3, 2'h0, base, 18'h0, 1'h0);
          chk("burst read", dq_out, shadow[{base[15:2], seq_low(i[1:0], 2'(k - 1), m[0])}]);
        end
      end
    end
    tally_and_finish();
  end

  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
